// File: hdl/opd_pkg.sv
package opd_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MSTAT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_JFROM = 8'h0c;
    localparam logic [7:0] ADDR_JTO = 8'h10;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam logic [2:0] MSTAT_RESET = 3'h0;
    localparam int STAGES = 6;
    localparam int ABANDON_LAST = 4;
    localparam logic [13:0] SYS_SEGMENT = 14'h2000;
    localparam logic [6:0] VBLOCK_SYSTEM = 7'h00;
    localparam logic [6:0] VBLOCK_OWN = 7'h01;
    localparam logic [3:0] LINK_REG = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OPD_DUMMY, OPD_LITERAL, OPD_INTREG, OPD_VSTORE, OPD_VARIABLE, OPD_STACKLOAD
    } opd_kind_t;

    typedef enum logic [1:0] {OPD_PH_IDLE, OPD_PH_AWAIT, OPD_PH_SECOND} opd_phase_t;

    // Order code digits are numbered from the most significant end, digit 0 first.
    typedef struct packed {
        logic valid;
        opd_kind_t kind;
        logic isStore;
        logic arith;
        logic modStore;
        logic orgOrder;
        logic toStack;
        logic special;
        logic [0:15] code;
        logic [3:0] regNum;
        logic [6:0] vBlock;
        logic [15:0] vLine;
    } opd_order_t;

    typedef struct packed {
        logic beat;
        opd_order_t order;
        logic xferJump;
        logic xferPredicted;
        logic xferLiteral;
        logic intEntry;
        logic procCall;
        logic [31:0] jumpTarget;
        logic [31:0] nextOrderAddr;
        logic [31:0] literalSource;
        logic [31:0] literalExt;
        logic litLong;
        logic [31:0] intRegValue;
        logic [13:0] nameSegment;
        logic inboundValid;
        logic [63:0] inboundData;
        logic vstoreReady;
        logic [63:0] vstoreData;
        logic localHit;
        logic bufHit;
    } opd_feed_t;

    typedef struct packed {
        logic newStream;
        logic jumpTraceWr;
        logic selfCopy;
        logic loadTarget;
        logic donorReq;
        logic acceptorReq;
        logic fetchInternal;
        logic loadInternal;
        logic internalInt;
        logic sacRead;
        logic sacWrite;
        logic bypassName;
        logic vlineRead;
        logic vlineLoad;
        logic vlineAct;
        logic vWait;
        logic eraseLocal;
        logic sendCopy;
        logic moveBack;
        logic oneUseCopy;
        logic insertMain;
        logic secondaryReq;
        logic stackStore;
        logic [63:0] outbound;
        logic [13:0] sacSegment;
        logic [15:0] sacAddr;
        logic [31:0] jumpFrom;
        logic [31:0] jumpTo;
    } opd_req_t;

    typedef struct packed {
        opd_order_t [STAGES-1:0] stage;
        logic [63:0] s4Op;
        logic s4Ready;
        opd_phase_t phase;
        logic [15:0] vstoreAddr;
        logic enable;
        logic [2:0] priv;
        logic [15:0] intCount;
        opd_req_t req;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } opd_state_t;
endpackage : opd_pkg

// File: hdl/opd_dispatch.sv
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// RL1: Abandon empties stages 0-4, requests new stream.
// RL2: Unpredicted literal jump records from/to addresses.
// RL3: Store-then-load splits into stack store, load.
// RL4: Operands leave outbound, return inbound register.
// RL5: Literal store raises internal interrupt only.
// RL6: Literal load assembled into stage-4 register.
// RL7: Code digits 0-2 choose load or self-copy.
// RL8: Own internal register stores interrupt; non-overlapped.
// RL9: Internal register shifted low, high digits cleared.
// RL10: Register zero link gets next order address.
// RL11: Foreign internal register runs donor then acceptor.
// RL12: Flags mark internal-register fetch or load.
// RL13: Unprivileged V-store order raises internal interrupt.
// RL14: Block 0 uses segment 8192, bypasses store.
// RL15: Block 1 own lines; others via controller.
// RL16: V-store load waits, fetches into stage 4.
// RL17: V-store store halts stage 3, gets operand.
// RL18: V-store store completes to line or controller.
// RL19: Arithmetic store hit erases local line.
// RL20: Arithmetic load hit sends copy, miss defers.
// RL21: Other accesses: move back, copy, or insert.
// RL22: Arithmetic variable store, or load miss, goes to secondary pipe.
// RL23: Each accepted beat without an abandon puts one order into stage 5.
// RL24: Dummy orders cause no requests or effects.
module opd_dispatch (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire opd_pkg::opd_feed_t feed,
    output opd_pkg::opd_req_t req,
    output logic orderTake,
    output logic holdBeat,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    opd_pkg::opd_state_t s;
    opd_pkg::opd_state_t next_s;
    opd_pkg::opd_order_t c4;
    opd_pkg::opd_order_t cur;
    logic abandon;
    logic priv;
    logic v4load;
    logic halt3;
    logic stall;
    logic advance;
    logic wrTake;
    logic rdTake;

    assign c4 = s.stage[4];
    assign cur = s.stage[5];
    assign abandon = feed.xferJump || feed.intEntry || feed.procCall;
    assign priv = |s.priv;
    assign v4load = c4.valid && c4.kind == opd_pkg::OPD_VSTORE && !c4.isStore && priv;
    // A V-store store waits at stage 3 until the stages ahead of it hold only dummies.
    assign halt3 = s.stage[3].valid && s.stage[3].kind == opd_pkg::OPD_VSTORE
        && s.stage[3].isStore && (s.stage[4].valid || s.stage[5].valid);
    assign stall = (s.phase != opd_pkg::OPD_PH_IDLE) || (v4load && !s.s4Ready);
    assign advance = feed.beat && !stall;
    assign holdBeat = stall;
    assign orderTake = advance && !abandon && !halt3 && s.enable
        && s.stage[0].kind != opd_pkg::OPD_STACKLOAD;
    assign wrTake = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
    assign rdTake = s_axi_arvalid && !s.rvalid;
    assign s_axi_awready = wrTake;
    assign s_axi_wready = wrTake;
    assign s_axi_arready = rdTake;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign req = s.req;

    always_comb begin
        opd_pkg::opd_order_t o3;
        logic own4;
        logic intr;
        o3 = s.stage[3];
        own4 = c4.code[10:11] == 2'b00;
        intr = 1'b0;
        next_s = s;
        next_s.req = '0;
        next_s.req.outbound = s.req.outbound;
        next_s.req.sacSegment = s.req.sacSegment;
        next_s.req.sacAddr = s.req.sacAddr;
        next_s.req.jumpFrom = s.req.jumpFrom;
        next_s.req.jumpTo = s.req.jumpTo;
        // Stage-4 V-store fetch while the stage-5 order waits.
        if (v4load && !s.s4Ready) begin
            next_s.req.vWait = 1'b1; // RL16
            if (c4.vBlock == opd_pkg::VBLOCK_OWN) begin
                next_s.req.vlineRead = 1'b1; // RL15
            end else begin
                next_s.req.sacRead = 1'b1; // RL15
                next_s.req.sacAddr = c4.vLine;
                next_s.req.bypassName = c4.vBlock == opd_pkg::VBLOCK_SYSTEM; // RL14
                next_s.req.sacSegment = (c4.vBlock == opd_pkg::VBLOCK_SYSTEM)
                    ? opd_pkg::SYS_SEGMENT : feed.nameSegment; // RL14
            end
            if (feed.vstoreReady) begin
                next_s.s4Op = feed.vstoreData; // RL16
                next_s.s4Ready = 1'b1;
            end
        end
        if (s.stage[3].valid && s.stage[3].kind == opd_pkg::OPD_VSTORE && s.stage[3].isStore) begin
            next_s.vstoreAddr = s.stage[3].vLine; // RL17
        end
        // Completion of an order waiting at stage 5.
        unique case (s.phase)
            opd_pkg::OPD_PH_IDLE: begin
            end
            opd_pkg::OPD_PH_AWAIT: begin
                if (feed.inboundValid) begin
                    next_s.phase = opd_pkg::OPD_PH_IDLE; // RL4
                    if (cur.kind == opd_pkg::OPD_INTREG) begin
                        next_s.s4Op = feed.inboundData; // RL11
                        next_s.phase = opd_pkg::OPD_PH_SECOND;
                    end else if (cur.kind == opd_pkg::OPD_VSTORE) begin
                        next_s.req.outbound = feed.inboundData;
                        if (cur.vBlock == opd_pkg::VBLOCK_OWN) begin
                            next_s.req.vlineLoad = 1'b1; // RL18
                            next_s.req.vlineAct = cur.special; // RL18
                        end else begin
                            next_s.req.sacWrite = 1'b1; // RL18
                            next_s.req.sacAddr = s.vstoreAddr; // RL18
                            next_s.req.bypassName = cur.vBlock == opd_pkg::VBLOCK_SYSTEM;
                            next_s.req.sacSegment = (cur.vBlock == opd_pkg::VBLOCK_SYSTEM)
                                ? opd_pkg::SYS_SEGMENT : feed.nameSegment; // RL14
                        end
                    end
                end
            end
            opd_pkg::OPD_PH_SECOND: begin
                if (feed.beat) begin
                    next_s.req.acceptorReq = 1'b1; // RL11
                    next_s.req.loadInternal = cur.isStore; // RL12
                    next_s.req.outbound = s.s4Op; // RL4
                    next_s.phase = opd_pkg::OPD_PH_IDLE;
                end
            end
        endcase
        if (abandon) begin
            for (int k = 0; k <= opd_pkg::ABANDON_LAST; k++) begin
                next_s.stage[k] = '0; // RL1
            end
            next_s.s4Ready = 1'b0;
            next_s.req.newStream = 1'b1; // RL1
            if (feed.xferJump && !feed.xferPredicted && feed.xferLiteral) begin
                next_s.req.jumpTraceWr = 1'b1; // RL2
                next_s.req.jumpFrom = feed.nextOrderAddr - 32'h1; // RL2
                next_s.req.jumpTo = feed.jumpTarget; // RL2
            end
        end else if (advance) begin
            next_s.stage[5] = c4; // RL23
            next_s.s4Ready = 1'b0;
            // Dispatch of the order entering stage 5; dummies fall through untouched.
            if (c4.valid) begin // RL24
                intr = (c4.kind == opd_pkg::OPD_LITERAL && c4.isStore) // RL5
                    || (c4.kind == opd_pkg::OPD_INTREG && own4 && c4.isStore) // RL8
                    || (c4.kind == opd_pkg::OPD_VSTORE && !priv); // RL13
                if (intr) begin
                    next_s.req.internalInt = 1'b1;
                    next_s.intCount = s.intCount + 16'h1;
                end else begin
                    unique case (c4.kind)
                        opd_pkg::OPD_LITERAL: begin
                            next_s.req.outbound = s.s4Op; // RL4
                            if (|c4.code[0:2]) begin
                                next_s.req.loadTarget = 1'b1; // RL7
                            end else begin
                                next_s.req.selfCopy = 1'b1; // RL7
                                next_s.phase = opd_pkg::OPD_PH_AWAIT;
                            end
                        end
                        opd_pkg::OPD_INTREG: begin
                            if (own4) begin
                                if (c4.regNum == opd_pkg::LINK_REG) begin
                                    next_s.req.outbound = {s.s4Op[63:32], feed.nextOrderAddr}; // RL10
                                end else begin
                                    next_s.req.outbound = {32'h0, s.s4Op[63:32]}; // RL9
                                end
                                next_s.req.loadTarget = 1'b1;
                            end else begin
                                next_s.req.donorReq = 1'b1; // RL11
                                next_s.req.fetchInternal = !c4.isStore; // RL12
                                next_s.phase = opd_pkg::OPD_PH_AWAIT;
                            end
                        end
                        opd_pkg::OPD_VSTORE: begin
                            if (!c4.isStore) begin
                                next_s.req.outbound = s.s4Op; // RL16
                                next_s.req.loadTarget = !c4.orgOrder;
                                next_s.req.selfCopy = c4.orgOrder;
                            end else begin
                                next_s.req.outbound = s.s4Op;
                                next_s.req.selfCopy = c4.orgOrder; // RL17
                                next_s.req.donorReq = !c4.orgOrder; // RL17
                                next_s.phase = opd_pkg::OPD_PH_AWAIT;
                            end
                        end
                        opd_pkg::OPD_VARIABLE: begin
                            if (c4.toStack) begin
                                next_s.req.stackStore = 1'b1; // RL3
                            end else if (c4.arith) begin
                                next_s.req.eraseLocal = c4.isStore && feed.localHit; // RL19
                                next_s.req.sendCopy = !c4.isStore && feed.localHit; // RL20
                                next_s.req.secondaryReq = c4.isStore || !feed.localHit; // RL22
                                if (!c4.isStore && feed.localHit) begin
                                    next_s.req.outbound = s.s4Op; // RL20
                                end
                            end else if (!feed.localHit) begin
                                if (feed.bufHit) begin
                                    next_s.req.moveBack = c4.isStore && c4.modStore; // RL21
                                    next_s.req.oneUseCopy = !(c4.isStore && c4.modStore); // RL21
                                end else begin
                                    next_s.req.insertMain = 1'b1; // RL21
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (halt3) begin
                next_s.stage[4] = '0; // RL17
            end else begin
                next_s.stage[4] = o3;
                next_s.s4Op = '0;
                if (o3.valid && o3.kind == opd_pkg::OPD_LITERAL && !o3.isStore) begin
                    next_s.s4Op = {feed.litLong ? feed.literalExt : 32'h0,
                        feed.literalSource}; // RL6
                end else if (o3.valid && o3.kind == opd_pkg::OPD_INTREG && !o3.isStore
                        && o3.code[10:11] == 2'b00) begin
                    next_s.s4Op = {feed.intRegValue, 32'h0}; // RL9
                end
                next_s.stage[3] = s.stage[2];
                next_s.stage[2] = s.stage[1];
                if (s.stage[0].kind == opd_pkg::OPD_STACKLOAD) begin
                    next_s.stage[1] = s.stage[0];
                    next_s.stage[1].kind = opd_pkg::OPD_VARIABLE; // RL3
                    next_s.stage[1].isStore = 1'b1; // RL3
                    next_s.stage[1].toStack = 1'b1; // RL3
                    next_s.stage[0].kind = opd_pkg::OPD_VARIABLE; // RL3
                    next_s.stage[0].isStore = 1'b0; // RL3
                end else begin
                    next_s.stage[1] = s.stage[0];
                    next_s.stage[0] = (s.enable && feed.order.valid) ? feed.order : '0;
                end
            end
        end
        // Register bus.
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wrTake) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = opd_pkg::RESP_OKAY;
            if (s_axi_awaddr == opd_pkg::ADDR_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_s.enable = s_axi_wdata[0];
                end
            end else if (s_axi_awaddr == opd_pkg::ADDR_MSTAT) begin
                if (s_axi_wstrb[0]) begin
                    next_s.priv = s_axi_wdata[2:0];
                end
            end else if (s_axi_awaddr != opd_pkg::ADDR_STATUS && s_axi_awaddr != opd_pkg::ADDR_JFROM
                    && s_axi_awaddr != opd_pkg::ADDR_JTO) begin
                next_s.bresp = opd_pkg::RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (rdTake) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = opd_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                opd_pkg::ADDR_CTRL: next_s.rdata = {31'h0, s.enable};
                opd_pkg::ADDR_MSTAT: next_s.rdata = {29'h0, s.priv};
                opd_pkg::ADDR_STATUS: next_s.rdata = {s.intCount, 12'h0, s.phase,
                    s.req.vWait, stall};
                opd_pkg::ADDR_JFROM: next_s.rdata = s.req.jumpFrom;
                opd_pkg::ADDR_JTO: next_s.rdata = s.req.jumpTo;
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = opd_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.enable <= opd_pkg::CTRL_ENABLE_RESET;
            s.priv <= opd_pkg::MSTAT_RESET;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seqAwaitReturn;
        s.phase == opd_pkg::OPD_PH_AWAIT && feed.inboundValid && cur.kind == opd_pkg::OPD_INTREG;
    endsequence
    sequence seqSecondBeat;
        s.phase == opd_pkg::OPD_PH_SECOND && feed.beat;
    endsequence

    chk_abandon_dummy: assert property (abandon |=> !s.stage[0].valid && !s.stage[1].valid // RL1
        && !s.stage[2].valid && !s.stage[3].valid && !s.stage[4].valid && s.req.newStream)
        else $error("abandon left a live order");
    chk_jump_trace: assert property (abandon && feed.xferJump && !feed.xferPredicted // RL2
        && feed.xferLiteral |=> s.req.jumpTraceWr
        && s.req.jumpFrom == $past(feed.nextOrderAddr) - 32'h1)
        else $error("jump trace not written");
    chk_split_stack: assert property (advance && !abandon && !halt3 // RL3
        && s.stage[0].kind == opd_pkg::OPD_STACKLOAD |=> s.stage[1].toStack && s.stage[1].isStore
        && s.stage[0].kind == opd_pkg::OPD_VARIABLE && !s.stage[0].isStore)
        else $error("store-then-load not split");
    chk_literal_intr: assert property (advance && !abandon && c4.valid // RL5
        && c4.kind == opd_pkg::OPD_LITERAL && c4.isStore |=> s.req.internalInt && !s.req.loadTarget
        && !s.req.selfCopy) else $error("literal store not trapped");
    chk_literal_route: assert property (advance && !abandon && c4.valid // RL7
        && c4.kind == opd_pkg::OPD_LITERAL && !c4.isStore
        |=> s.req.loadTarget == (|$past(c4.code[0:2]))
        && s.req.selfCopy != s.req.loadTarget) else $error("literal route wrong");
    chk_link_load: assert property (advance && !abandon && c4.valid // RL10
        && c4.kind == opd_pkg::OPD_INTREG && !c4.isStore && c4.code[10:11] == 2'b00
        && c4.regNum == opd_pkg::LINK_REG
        |=> s.req.outbound[31:0] == $past(feed.nextOrderAddr)) else $error("link not loaded");
    chk_vstore_priv: assert property (advance && !abandon && c4.valid // RL13
        && c4.kind == opd_pkg::OPD_VSTORE && s.priv == 3'h0
        |=> s.req.internalInt && !s.req.donorReq)
        else $error("unprivileged V-store not trapped");
    chk_vwait_hold: assert property (v4load && !s.s4Ready |-> !advance ##1 s.req.vWait) // RL16
        else $error("V-store load did not wait");
    chk_second_part: assert property (seqAwaitReturn ##1 seqSecondBeat // RL11
        |=> s.req.acceptorReq) else $error("second part not sent");
    chk_arith_erase: assert property (advance && !abandon && c4.valid // RL19
        && c4.kind == opd_pkg::OPD_VARIABLE && c4.arith && c4.isStore && !c4.toStack
        && feed.localHit
        |=> s.req.eraseLocal && s.req.secondaryReq) else $error("arithmetic store hit not erased");
    chk_dummy_quiet: assert property (advance && !abandon && !c4.valid // RL24
        && s.phase == opd_pkg::OPD_PH_IDLE
        |=> !s.req.donorReq && !s.req.selfCopy && !s.req.loadTarget && !s.req.internalInt)
        else $error("dummy order made a request");
endmodule : opd_dispatch

// File: verification/opd_far_side.sv
`timescale 1ns/10ps
module opd_far_side #(
    parameter logic [63:0] DONOR = 64'h0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire opd_pkg::opd_req_t req,
    output logic inboundValid,
    output logic [63:0] inboundData,
    output logic vstoreReady,
    output logic [63:0] vstoreData
);
    logic [2:0] dly;
    logic [63:0] held;
    // Operands come back a few cycles late; idle data lines toggle so stale values never match.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly <= '0;
            held <= '0;
            inboundValid <= 1'b0;
            inboundData <= '0;
            vstoreReady <= 1'b0;
            vstoreData <= '0;
        end else begin
            dly <= {dly[1:0], req.selfCopy | req.donorReq};
            if (req.selfCopy) held <= req.outbound;
            if (req.donorReq) held <= DONOR;
            inboundValid <= dly[2];
            inboundData <= dly[2] ? held : ~inboundData;
            vstoreReady <= req.sacRead && !vstoreReady;
            vstoreData <= req.sacRead ? DONOR : ~vstoreData;
        end
    end
endmodule : opd_far_side

// File: verification/tb_operand_pipeline_dispatch.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
`define WT(c) begin i = 0; @(negedge core_clk); while (!(c)) begin @(negedge core_clk); \
    i++; if (i > 300) begin errors++; end_sim(); end end end
module tb_operand_pipeline_dispatch;
    localparam logic [63:0] DONOR = 64'h0000_0000_5a3c_96e1;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    opd_pkg::opd_feed_t fd, feed;
    opd_pkg::opd_req_t req;
    logic orderTake, holdBeat, wrV, arV, bRdy, rRdy, awRdy, wRdy, bv, arRdy, rv, inV, vsR;
    logic [7:0] adr;
    logic [3:0] ws;
    logic [31:0] wd, rd, r, lit;
    logic [1:0] br, rr;
    logic [63:0] inD, vsD;
    logic [38:0] evq[$], n;
    logic [33:0] axq[$], e;
    logic [5:0] ev;
    int errors = 0, check_count = 0, i, k;
    always #20 core_clk = ~core_clk;
    always_comb begin
        feed = fd;
        {feed.inboundValid, feed.inboundData, feed.vstoreReady, feed.vstoreData}
            = {inV, inD, vsR, vsD};
    end
    opd_dispatch dut_u (.core_clk(core_clk), .rst_n(rst_n), .feed(feed), .req(req),
        .orderTake(orderTake), .holdBeat(holdBeat), .s_axi_awaddr(adr), .s_axi_awvalid(wrV),
        .s_axi_awready(awRdy), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wrV),
        .s_axi_wready(wRdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
        .s_axi_araddr(adr), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rRdy));
    opd_far_side #(.DONOR(DONOR)) far_u (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .inboundValid(inV), .inboundData(inD), .vstoreReady(vsR), .vstoreData(vsD));
    always @(posedge core_clk) begin
        ev = {req.newStream, req.jumpTraceWr, req.internalInt, req.loadTarget, req.selfCopy,
            req.acceptorReq};
        if (ev !== 6'h0) begin
            n = evq.size() ? evq.pop_front() : 39'h0;
            `CHK(ev, n[38:33])
            if (n[32]) `CHK(req.jumpTraceWr ? req.jumpTo : req.outbound[31:0], n[31:0])
        end
        if ((bv && bRdy) || (rv && rRdy)) begin
            e = axq.pop_front();
            `CHK((bv && bRdy) ? {br, 32'h0} : {rr, rd}, e)
        end
        if (fd.beat) `CHK(orderTake, !holdBeat)
    end
    function logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lf
    function opd_pkg::opd_order_t mk(opd_pkg::opd_kind_t kd, logic st, logic [15:0] c);
        mk = '0;
        {mk.valid, mk.kind, mk.isStore, mk.code} = {1'b1, kd, st, c};
    endfunction : mk
    task end_sim();
        errors += evq.size() + axq.size();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
        axq.push_back(x);
        @(posedge core_clk);
        adr <= a;
        wd <= d;
        if (w) begin
            {wrV, bRdy} <= 2'b11;
            `WT(awRdy && wRdy)
            @(posedge core_clk);
            wrV <= 1'b0;
            `WT(bv)
        end else begin
            {arV, rRdy} <= 2'b11;
            `WT(arRdy)
            @(posedge core_clk);
            arV <= 1'b0;
            `WT(rv)
        end
        @(posedge core_clk);
        {bRdy, rRdy} <= 2'b00;
    endtask : axi
    task bt(input opd_pkg::opd_order_t o);
        // A returned operand frees the next beat, which a second order part may need.
        `WT(!holdBeat || inV)
        @(posedge core_clk);
        {fd.beat, fd.order} <= {1'b1, o};
        @(posedge core_clk);
        {fd.beat, fd.order} <= '0;
    endtask : bt
    task run(input opd_pkg::opd_order_t o, input logic [38:0] x);
        evq.push_back(x);
        bt(o);
        repeat (8) bt('0);
    endtask : run
    initial begin
        fd = '0;
        {wrV, arV, bRdy, rRdy, adr, wd, ws} = {4'h0, 8'h0, 32'h0, 4'hf};
        fd.nextOrderAddr = 32'h100;
        r = 32'h0ba98b24;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        axi(1'b0, opd_pkg::ADDR_MSTAT, 32'h0, {opd_pkg::RESP_OKAY, 32'h0});
        axi(1'b0, 8'hfc, 32'h0, {opd_pkg::RESP_SLVERR, 32'h0});
        $display("register test done");
        lit = lf(r);
        fd.literalSource <= lit;
        run(mk(opd_pkg::OPD_LITERAL, 1'b0, 16'h8000), {6'b000100, 1'b1, lit});
        run(mk(opd_pkg::OPD_LITERAL, 1'b0, 16'h0000), {6'b000010, 1'b1, lit});
        run(mk(opd_pkg::OPD_LITERAL, 1'b1, 16'h8000), {6'b001000, 33'h0});
        run(mk(opd_pkg::OPD_INTREG, 1'b1, 16'h8000), {6'b001000, 33'h0});
        run(mk(opd_pkg::OPD_INTREG, 1'b0, 16'h8000), {6'b000100, 1'b1, 32'h100});
        run(mk(opd_pkg::OPD_VSTORE, 1'b0, 16'h8000), {6'b001000, 33'h0});
        run(mk(opd_pkg::OPD_INTREG, 1'b0, 16'h8020), {6'b000001, 1'b1, DONOR[31:0]});
        $display("order test done");
        bt(mk(opd_pkg::OPD_LITERAL, 1'b0, 16'h8000));
        bt('0);
        for (k = 0; k < 4; k++) begin
            r = lf(r);
            if (k == 0) lit = r;
            evq.push_back(k ? {6'b100000, 33'h0} : {6'b110000, 1'b1, r});
            @(posedge core_clk);
            {fd.jumpTarget, fd.xferLiteral, fd.xferPredicted} <= {r, 1'b1, k == 1};
            {fd.xferJump, fd.intEntry, fd.procCall} <= {k < 2, k == 2, k == 3};
            @(posedge core_clk);
            {fd.xferJump, fd.intEntry, fd.procCall} <= 3'h0;
            repeat (4) @(posedge core_clk);
        end
        repeat (8) bt('0);
        axi(1'b0, opd_pkg::ADDR_JFROM, 32'h0, {opd_pkg::RESP_OKAY, 32'hff});
        axi(1'b0, opd_pkg::ADDR_JTO, 32'h0, {opd_pkg::RESP_OKAY, lit});
        axi(1'b1, opd_pkg::ADDR_MSTAT, 32'h5, {opd_pkg::RESP_OKAY, 32'h0});
        axi(1'b0, opd_pkg::ADDR_MSTAT, 32'h0, {opd_pkg::RESP_OKAY, 32'h5});
        $display("abandon test done");
        run(mk(opd_pkg::OPD_VSTORE, 1'b0, 16'h8000), {6'b000100, 1'b1, DONOR[31:0]});
        $display("vstore test done");
        end_sim();
    end
endmodule : tb_operand_pipeline_dispatch
